/* File: shared/fes_pkg.sv */
package fes_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int FA_W = 24;
	localparam int NUM_BLK = 14;
	localparam int NUM_SMALL = 8;
	localparam int AREA_W = 3;

	typedef logic [ADDR_W-1:0] fes_addr_t;
	typedef logic [DATA_W-1:0] fes_data_t;
	typedef logic [FA_W-1:0] fes_faddr_t;

	// Register offsets
	localparam fes_addr_t OFS_CTRL = 8'h00;
	localparam fes_addr_t OFS_EB_LO = 8'h01;
	localparam fes_addr_t OFS_EB_HI = 8'h02;
	localparam fes_addr_t OFS_RAMEMU = 8'h03;
	localparam fes_addr_t OFS_STATUS = 8'h04;

	// Field positions
	localparam int CTRL_PERMIT_BIT = 6;
	localparam int HI_BLK13_BIT = 5;
	localparam int HI_BLK12_BIT = 4;
	localparam int HI_SEL_W = 6;
	localparam int RE_SEL_BIT = 3;
	localparam int RE_STORE_W = 5;
	localparam int ST_OVL_BIT = 0;
	localparam int ST_ERASE_BIT = 1;
	localparam int ST_HIGH_BIT = 2;
	localparam int ST_LARGE_BIT = 3;
	localparam int ST_IDX_LSB = 4;

	// Reset values
	localparam fes_data_t RST_CTRL = 8'h00;
	localparam fes_data_t RST_EB = 8'h00;
	localparam fes_data_t RST_RAMEMU = 8'h00;

	// Flash map
	localparam fes_faddr_t LOW_BASE = 24'h000000;
	localparam fes_faddr_t HIGH_BASE = 24'h100000;
	localparam fes_faddr_t AREA_SIZE = 24'h001000;
	localparam fes_faddr_t BLK_START [NUM_BLK] = '{
		24'h000000, 24'h001000, 24'h002000, 24'h003000,
		24'h004000, 24'h005000, 24'h006000, 24'h007000,
		24'h008000, 24'h010000, 24'h020000, 24'h030000,
		24'h040000, 24'h050000};
	localparam fes_faddr_t BLK_LAST [NUM_BLK] = '{
		24'h000fff, 24'h001fff, 24'h002fff, 24'h003fff,
		24'h004fff, 24'h005fff, 24'h006fff, 24'h007fff,
		24'h00ffff, 24'h01ffff, 24'h02ffff, 24'h03ffff,
		24'h04ffff, 24'h05ffff};
endpackage

/* File: shared/fes_map_if.sv */
`timescale 1ns/1ps
// Request from the register side, answer from the address decoder
interface fes_map_if;
	import fes_pkg::*;
	logic [NUM_BLK-1:0] blockSel;
	logic [AREA_W-1:0] areaSel;
	logic overlayOn;
	logic highMap;
	logic eraseValid;
	fes_faddr_t eraseStart;
	fes_faddr_t eraseLast;
	fes_faddr_t overlayStart;
	fes_faddr_t overlayLast;
	modport ctl (output blockSel, output areaSel, output overlayOn, output highMap,
		input eraseValid, input eraseStart, input eraseLast,
		input overlayStart, input overlayLast);
	modport dec (input blockSel, input areaSel, input overlayOn, input highMap,
		output eraseValid, output eraseStart, output eraseLast,
		output overlayStart, output overlayLast);
endinterface

/* File: verilog/fes_map.sv */
`timescale 1ns/1ps
// Combinational block-to-address decoder
module fes_map (
	fes_map_if.dec mp
);
	import fes_pkg::*;

	fes_faddr_t startTerm [NUM_BLK];
	fes_faddr_t lastTerm [NUM_BLK];
	fes_faddr_t base;

	// High map modes shift everything by one base
	assign base = mp.highMap ? HIGH_BASE : LOW_BASE;

	// Selection is one-hot, so an OR of gated terms is the mux
	genvar i;
	generate
		for (i = 0; i < NUM_BLK; i++) begin : gBlk
			assign startTerm[i] = mp.blockSel[i] ? BLK_START[i] : '0;
			assign lastTerm[i] = mp.blockSel[i] ? BLK_LAST[i] : '0;
		end
	endgenerate

	// Erase range of the selected block
	always_comb begin
		fes_faddr_t s;
		fes_faddr_t l;
		s = '0;
		l = '0;
		for (int k = 0; k < NUM_BLK; k++) begin
			s = s | startTerm[k];
			l = l | lastTerm[k];
		end
		mp.eraseValid = |mp.blockSel;
		mp.eraseStart = mp.eraseValid ? (base | s) : '0;
		mp.eraseLast = mp.eraseValid ? (base | l) : '0;
	end

	// Overlay window: one 4-kbyte small block per area code
	always_comb begin
		fes_faddr_t a;
		a = BLK_START[mp.areaSel];
		mp.overlayStart = mp.overlayOn ? (base | a) : '0;
		mp.overlayLast = mp.overlayOn ? ((base | a) + (AREA_SIZE - 24'h000001)) : '0;
	end
endmodule // fes_map

/* File: verilog/fes_top.sv */
`timescale 1ns/1ps
// Erase block select and RAM overlay registers
module fes_top #(
	parameter bit LARGE_FLASH = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire fes_pkg::fes_addr_t regAddr,
	input wire fes_pkg::fes_data_t regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output fes_pkg::fes_data_t regRdData,
	input wire logic memMapHighPin,
	output logic [fes_pkg::NUM_BLK-1:0] eraseBlockSel,
	output logic eraseValid,
	output fes_pkg::fes_faddr_t eraseStart,
	output fes_pkg::fes_faddr_t eraseLast,
	output logic overlayOn,
	output fes_pkg::fes_faddr_t overlayStart,
	output fes_pkg::fes_faddr_t overlayLast,
	output logic flashProtect
);
	import fes_pkg::*;

	localparam logic [HI_SEL_W-1:0] HI_MASK_SMALL = 6'h0f;
	localparam logic [HI_SEL_W-1:0] HI_MASK_LARGE = 6'h3f;
	localparam logic [HI_SEL_W-1:0] HI_MASK = LARGE_FLASH ? HI_MASK_LARGE : HI_MASK_SMALL;

	fes_map_if mp ();

	// Register state
	logic softwareWritePermit_q;
	fes_data_t eraseLower_q;
	fes_data_t eraseLower_d;
	fes_data_t eraseUpper_q;
	fes_data_t eraseUpper_d;
	logic [RE_STORE_W-1:0] ramEmu_q;
	fes_data_t rdData_q;
	logic syncA_q;
	logic syncB_q;

	// Decode of the bus strobes
	logic wrCtrl;
	logic wrLower;
	logic wrUpper;
	logic wrRamEmu;
	assign wrCtrl = regWrStrobe && (regAddr == OFS_CTRL);
	assign wrLower = regWrStrobe && (regAddr == OFS_EB_LO);
	assign wrUpper = regWrStrobe && (regAddr == OFS_EB_HI);
	assign wrRamEmu = regWrStrobe && (regAddr == OFS_RAMEMU);

	// Mode pin is asynchronous to clk_sys
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			syncA_q <= 1'b0;
			syncB_q <= 1'b0;
		end else begin
			syncA_q <= memMapHighPin;
			syncB_q <= syncA_q;
		end
	end

	// Write permit bit in the control register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			softwareWritePermit_q <= RST_CTRL[CTRL_PERMIT_BIT];
		end else if (wrCtrl) begin
			softwareWritePermit_q <= regWrData[CTRL_PERMIT_BIT];
		end
	end

	// Candidate select values after this cycle's write
	logic [NUM_BLK-1:0] selCand;
	logic [4:0] selCount;
	always_comb begin
		eraseLower_d = eraseLower_q;
		eraseUpper_d = eraseUpper_q;
		if (wrLower) begin
			eraseLower_d = regWrData;
		end
		if (wrUpper) begin
			// Missing blocks in the small part keep their zero
			eraseUpper_d = {regWrData[7:HI_SEL_W],
				regWrData[HI_SEL_W-1:0] & HI_MASK};
		end
		selCand = {eraseUpper_d[HI_SEL_W-1:0], eraseLower_d};
		selCount = '0;
		for (int k = 0; k < NUM_BLK; k++) begin
			selCount = selCount + 5'(selCand[k]);
		end
	end

	// Both select registers share one clear path
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			eraseLower_q <= RST_EB;
			eraseUpper_q <= RST_EB;
		end else if (!softwareWritePermit_q) begin
			// Held at zero, so writes cannot set any bit
			eraseLower_q <= RST_EB;
			eraseUpper_q <= RST_EB;
		end else if (selCount > 5'd1) begin
			// Ambiguous target: drop every select bit
			eraseLower_q <= RST_EB;
			eraseUpper_q <= RST_EB;
		end else begin
			eraseLower_q <= eraseLower_d;
			eraseUpper_q <= eraseUpper_d;
		end
	end

	// Emulation register: only bits 4..0 are stored
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ramEmu_q <= RST_RAMEMU[RE_STORE_W-1:0];
		end else if (wrRamEmu) begin
			ramEmu_q <= regWrData[RE_STORE_W-1:0];
		end
	end

	// Feed the decoder
	assign mp.blockSel = {eraseUpper_q[HI_SEL_W-1:0], eraseLower_q};
	assign mp.areaSel = ramEmu_q[AREA_W-1:0];
	assign mp.overlayOn = ramEmu_q[RE_SEL_BIT];
	assign mp.highMap = syncB_q;

	fes_map uMap (
		.mp(mp)
	);

	// Registered copies so data outputs come from flops
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			eraseBlockSel <= '0;
			eraseValid <= 1'b0;
			eraseStart <= '0;
			eraseLast <= '0;
		end else begin
			eraseBlockSel <= mp.blockSel;
			eraseValid <= mp.eraseValid;
			eraseStart <= mp.eraseStart;
			eraseLast <= mp.eraseLast;
		end
	end

	// Overlay outputs; emulation protects the whole array
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overlayOn <= 1'b0;
			overlayStart <= '0;
			overlayLast <= '0;
			flashProtect <= 1'b0;
		end else begin
			overlayOn <= mp.overlayOn;
			overlayStart <= mp.overlayStart;
			overlayLast <= mp.overlayLast;
			flashProtect <= mp.overlayOn;
		end
	end

	// Index of the selected block for the status register
	logic [3:0] selIndex;
	always_comb begin
		selIndex = '0;
		for (int k = 0; k < NUM_BLK; k++) begin
			if (mp.blockSel[k]) begin
				selIndex = 4'(k);
			end
		end
	end

	// Read mux; unmapped addresses read zero
	fes_data_t rdMux;
	always_comb begin
		rdMux = '0;
		unique case (regAddr)
			OFS_CTRL: rdMux[CTRL_PERMIT_BIT] = softwareWritePermit_q;
			OFS_EB_LO: rdMux = eraseLower_q;
			OFS_EB_HI: rdMux = eraseUpper_q;
			OFS_RAMEMU: rdMux[RE_STORE_W-1:0] = ramEmu_q;
			OFS_STATUS: begin
				rdMux[ST_OVL_BIT] = mp.overlayOn;
				rdMux[ST_ERASE_BIT] = mp.eraseValid;
				rdMux[ST_HIGH_BIT] = syncB_q;
				rdMux[ST_LARGE_BIT] = LARGE_FLASH;
				rdMux[DATA_W-1:ST_IDX_LSB] = selIndex;
			end
			default: rdMux = '0;
		endcase
	end

	// Read data stands for one cycle only, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdData_q <= '0;
		end else begin
			rdData_q <= regRdStrobe ? rdMux : '0;
		end
	end
	assign regRdData = rdData_q;
endmodule // fes_top

/* File: testbench/fes_top_chk.sv */
`timescale 1ns/1ps
// Port relations of the erase select and overlay outputs
module fes_top_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire fes_pkg::fes_addr_t regAddr,
	input wire fes_pkg::fes_data_t regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	input wire fes_pkg::fes_data_t regRdData,
	input wire logic memMapHighPin,
	input wire logic [fes_pkg::NUM_BLK-1:0] eraseBlockSel,
	input wire logic eraseValid,
	input wire fes_pkg::fes_faddr_t eraseStart,
	input wire fes_pkg::fes_faddr_t eraseLast,
	input wire logic overlayOn,
	input wire fes_pkg::fes_faddr_t overlayStart,
	input wire fes_pkg::fes_faddr_t overlayLast,
	input wire logic flashProtect
);
	import fes_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Never two blocks at once, not even for one cycle
	chk_sel_onehot: assert property ($onehot0(eraseBlockSel))
		else $error("two blocks selected");
	chk_blk8_span: assert property (eraseBlockSel[8] |->
		eraseStart[19:0] == 20'h08000 && eraseLast == eraseStart + 24'h7fff)
		else $error("block 8 span wrong");
	// Permit off reaches the outputs three edges on
	chk_permit_off: assert property (regWrStrobe && regAddr == OFS_CTRL &&
		!regWrData[CTRL_PERMIT_BIT] |-> ##3 !eraseValid)
		else $error("selection kept without permit");
	chk_ovl_follow: assert property (regWrStrobe && regAddr == OFS_RAMEMU |->
		##2 overlayOn == $past(regWrData[RE_SEL_BIT], 2))
		else $error("overlay does not follow select bit");
	chk_prot_ovl: assert property (flashProtect == overlayOn)
		else $error("protect differs from overlay");
	chk_ovl_area: assert property (overlayOn |-> (overlayStart & 24'hef8fff) == 24'h0 &&
		overlayLast == overlayStart + 24'hfff)
		else $error("overlay area wrong");
	chk_ovl_off: assert property (!overlayOn |-> overlayStart == 24'h0 && overlayLast == 24'h0)
		else $error("overlay range while off");
	chk_emu_rsvd: assert property (regRdStrobe && regAddr == OFS_RAMEMU |=> regRdData[7:5] == 3'h0)
		else $error("reserved bits read nonzero");
	cover property (eraseValid && eraseStart[20]);
	cover property (overlayOn && overlayStart[20]);
	cover property (regWrStrobe && regAddr == OFS_CTRL && eraseValid);
endmodule // fes_top_chk

/* File: testbench/fes_top_tb.sv */
`timescale 1ns/1ps
// Directed checks of erase select and RAM overlay registers
module fes_top_tb;
	import fes_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	fes_addr_t regAddr = 8'h00;
	fes_data_t regWrData = 8'h00;
	logic regWrStrobe = 1'b0;
	logic regRdStrobe = 1'b0;
	logic memMapHighPin = 1'b0;
	fes_data_t regRdData;
	logic [NUM_BLK-1:0] eraseBlockSel;
	logic eraseValid, overlayOn, flashProtect;
	fes_faddr_t eraseStart, eraseLast, overlayStart, overlayLast;
	fes_data_t smallRdData;
	logic [NUM_BLK-1:0] smallSel;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #5 clk_sys = ~clk_sys;
	fes_top #(.LARGE_FLASH(1'b1)) dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
		.regRdData(regRdData), .memMapHighPin(memMapHighPin), .eraseBlockSel(eraseBlockSel),
		.eraseValid(eraseValid), .eraseStart(eraseStart), .eraseLast(eraseLast),
		.overlayOn(overlayOn), .overlayStart(overlayStart), .overlayLast(overlayLast),
		.flashProtect(flashProtect));
	// Small flash part on the same bus: upper blocks 12 and 13 do not exist
	fes_top #(.LARGE_FLASH(1'b0)) dut_small_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
		.regRdData(smallRdData), .memMapHighPin(memMapHighPin), .eraseBlockSel(smallSel),
		.eraseValid(), .eraseStart(), .eraseLast(), .overlayOn(), .overlayStart(),
		.overlayLast(), .flashProtect());
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Two extra edges so the derived outputs have landed on return
	task automatic wr(input fes_addr_t a, input fes_data_t d);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge clk_sys);
		regWrStrobe <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic rd(input fes_addr_t a, input fes_data_t exp, input string what);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge clk_sys);
		regRdStrobe <= 1'b0;
		// Read data stands only until the next edge, so look mid-cycle
		@(negedge clk_sys);
		chk(what, 24'(regRdData), 24'(exp));
		@(posedge clk_sys);
	endtask
	task automatic t_reset();
		for (int a = 0; a < 4; a++) rd(fes_addr_t'(a), 8'h00, "reset");
		chk("ovl rst", 24'({eraseValid, overlayOn, flashProtect}), 24'h0);
		rd(OFS_STATUS, 8'h08, "status rst");
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00, "unmapped");
	endtask
	// Selection refused without permit, cleared on two bits or permit loss
	task automatic t_refuse();
		wr(OFS_EB_HI, 8'h01);
		wr(OFS_EB_LO, 8'h80);
		rd(OFS_EB_HI, 8'h00, "hi nopermit");
		rd(OFS_EB_LO, 8'h00, "lo nopermit");
		wr(OFS_CTRL, 8'h40);
		wr(OFS_EB_LO, 8'h01);
		wr(OFS_EB_HI, 8'h20);
		rd(OFS_EB_LO, 8'h00, "lo two");
		rd(OFS_EB_HI, 8'h00, "hi two");
		wr(OFS_EB_HI, 8'h06);
		chk("valid two", 24'(eraseValid), 24'h0);
		wr(OFS_EB_HI, 8'h08);
		wr(OFS_CTRL, 8'h00);
		rd(OFS_EB_HI, 8'h00, "hi off");
		chk("sel off", 24'(eraseBlockSel), 24'h0);
		wr(OFS_CTRL, 8'h40);
	endtask
	// Block 12 written: kept by the large part, masked off in the small one
	task automatic t_small();
		wr(OFS_EB_HI, 8'h10);
		regAddr <= OFS_EB_HI;
		regRdStrobe <= 1'b1;
		@(posedge clk_sys);
		regRdStrobe <= 1'b0;
		@(negedge clk_sys);
		chk("small hi", 24'(smallRdData), 24'h0);
		chk("large hi", 24'(regRdData), 24'h10);
		@(posedge clk_sys);
		chk("small sel", 24'(smallSel), 24'h0);
		wr(OFS_EB_HI, 8'h00);
	endtask
	task automatic t_blocks(input logic hi);
		fes_faddr_t base, size;
		for (int k = 0; k < NUM_BLK; k++) begin
			base = (k < 8) ? fes_faddr_t'(k) << 12 : (k == 8) ? 24'h8000 : fes_faddr_t'(k - 8) << 16;
			size = (k < 8) ? 24'h1000 : (k == 8) ? 24'h8000 : 24'h10000;
			base = base | (hi ? 24'h100000 : 24'h0);
			wr(k < 8 ? OFS_EB_LO : OFS_EB_HI, fes_data_t'(1 << (k < 8 ? k : k - 8)));
			chk("sel", 24'(eraseBlockSel), 24'(1 << k));
			chk("start", eraseStart, base);
			chk("last", eraseLast, base + size - 24'h1);
			rd(OFS_STATUS, fes_data_t'({4'(k), 1'b1, hi, 2'b10}), "status");
			wr(k < 8 ? OFS_EB_LO : OFS_EB_HI, 8'h00);
		end
	endtask
	task automatic t_overlay(input logic hi);
		for (int c = 0; c < 8; c++) begin
			// Bench never touches the overlaid area, and waits before looking
			wr(OFS_RAMEMU, 8'h08 | fes_data_t'(c));
			chk("ovl on", 24'({overlayOn, flashProtect}), 24'h3);
			chk("ovl start", overlayStart, (24'(c) << 12) | (hi ? 24'h100000 : 24'h0));
			chk("ovl last", overlayLast, (24'(c) << 12) + (hi ? 24'h100fff : 24'hfff));
		end
		rd(OFS_STATUS, fes_data_t'({4'h0, 1'b1, hi, 2'b01}), "status ovl");
		wr(OFS_RAMEMU, 8'hf7);
		rd(OFS_RAMEMU, 8'h17, "emu rsvd");
		wr(OFS_RAMEMU, 8'h05);
		chk("ovl off", 24'({overlayOn, flashProtect}), 24'h0);
	endtask
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Ceiling far above the few hundred cycles the sequence needs
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_refuse();
		t_small();
		t_blocks(1'b0);
		t_overlay(1'b0);
		memMapHighPin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		t_blocks(1'b1);
		t_overlay(1'b1);
		end_sim();
	end
endmodule // fes_top_tb
bind fes_top fes_top_chk chk_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
	.regRdData(regRdData), .memMapHighPin(memMapHighPin), .eraseBlockSel(eraseBlockSel),
	.eraseValid(eraseValid), .eraseStart(eraseStart), .eraseLast(eraseLast),
	.overlayOn(overlayOn), .overlayStart(overlayStart), .overlayLast(overlayLast),
	.flashProtect(flashProtect));
